// ---- rtl/lms_pkg.sv ----
// Package with register map, field layout and carrier types of the source-address block.
package lms_pkg;

    // ------------------------------------------------------------
    // Register byte offsets on the APB window
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_PAGE0_SRC = 8'h00;
    localparam logic [7:0] OFF_PAGE1_SRC = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_LAST_SRC = 8'h0C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int UPPER_MSB = 28;
    localparam int UPPER_LSB = 10;
    localparam int SIZE_MSB = 5;
    localparam int SIZE_LSB = 0;
    localparam int SIZE_W = SIZE_MSB - SIZE_LSB + 1;
    localparam int UPPER_W = UPPER_MSB - UPPER_LSB + 1;
    localparam int PADDR_W = UPPER_MSB + 1;
    localparam int SEL_ADDR_LSB = 10;
    localparam int CTRL_XLAT_BIT = 0;
    localparam int CTRL_PROT_BIT = 1;

    // Writable bits of a source register: 28..10 and 5..0.
    localparam logic [31:0] SRC_WMASK = 32'h1FFFFC3F;
    localparam logic [31:0] CTRL_WMASK = 32'h00000003;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [UPPER_W-1:0] UPPER_RST = 19'h00000;
    localparam logic [SIZE_W-1:0] SIZE_RST = 6'h00;
    localparam logic CTRL_XLAT_RST = 1'b0;
    localparam logic CTRL_PROT_RST = 1'b0;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic page;
        logic [PADDR_W-1:0] operand;
    } lms_xfer_req_s;

    typedef struct packed {
        logic fromRegs;
        logic [PADDR_W-1:0] srcAddr;
    } lms_xfer_rsp_s;

    typedef struct packed {
        logic [UPPER_W-1:0] upper;
        logic [SIZE_W-1:0] sizeSel;
    } lms_src_reg_s;

endpackage

// ---- rtl/lms_addr_mux.sv ----
// Per-bit source address merge of register upper field and operand address.
`timescale 1ns/10ps
module lms_addr_mux (
    input wire logic useRegs,
    input wire lms_pkg::lms_src_reg_s srcReg,
    input wire logic [lms_pkg::PADDR_W-1:0] operand,
    output logic [lms_pkg::PADDR_W-1:0] srcAddr
);

    // ------------------------------------------------------------
    // Bit merge
    // ------------------------------------------------------------
    // Bits below the select window always come from the operand.
    assign srcAddr[lms_pkg::SEL_ADDR_LSB-1:0] =
        operand[lms_pkg::SEL_ADDR_LSB-1:0];

    // Above the window the register field is used whenever the
    // register path is active, otherwise the operand passes.
    assign srcAddr[lms_pkg::PADDR_W-1:lms_pkg::SEL_ADDR_LSB+lms_pkg::SIZE_W] =
        useRegs ? srcReg.upper[lms_pkg::UPPER_W-1:lms_pkg::SIZE_W]
                : operand[lms_pkg::PADDR_W-1:
                          lms_pkg::SEL_ADDR_LSB+lms_pkg::SIZE_W];

    // One select bit per address bit: select bit n steers bit n+10.
    // Zero picks the operand, one picks the register field on the register path.
    genvar gi;
    generate
        for (gi = 0; gi < lms_pkg::SIZE_W; gi++) begin : gSel
            assign srcAddr[lms_pkg::SEL_ADDR_LSB+gi] =
                (useRegs && srcReg.sizeSel[gi]) ? srcReg.upper[gi]
                : operand[lms_pkg::SEL_ADDR_LSB+gi];
        end
    endgenerate

endmodule

// ---- rtl/lms_src_addr.sv ----
// Top of the local-memory block-transfer source address unit with APB slave.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/10ps

module lms_src_addr (
    input wire logic sys_clk,
    input wire logic sys_rst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Transfer request from the block-transfer engine.
    input wire logic xferReq,
    input wire lms_pkg::lms_xfer_req_s xferIn,
    output logic xferDone,
    output lms_pkg::lms_xfer_rsp_s xferOut,
    // Mode outputs toward the translation and protection logic.
    output logic addressTranslationEnable,
    output logic onchipMemoryProtectionEnable,
    output logic protCheckActive
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    lms_pkg::lms_src_reg_s srcReg_r [2];
    logic xlatEn_r;
    logic protEn_r;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic decErr_r;
    logic decErr_nxt;
    logic xferDone_r;
    lms_pkg::lms_xfer_rsp_s xferOut_r;
    logic [lms_pkg::PADDR_W-1:0] lastSrc_r;

    logic setupPhase;
    logic accessPhase;
    logic wrAccess;
    logic [31:0] byteMask;
    logic useRegs;
    logic [lms_pkg::PADDR_W-1:0] mergedAddr;
    lms_pkg::lms_src_reg_s selReg;

    // ------------------------------------------------------------
    // APB phase decode
    // ------------------------------------------------------------
    // The slave never inserts wait states; read data is prepared in
    // the setup cycle so that it leaves a flip-flop in the access cycle.
    assign setupPhase = psel && !penable;
    assign accessPhase = psel && penable;
    assign wrAccess = accessPhase && pwrite && !decErr_r;
    assign pready = 1'b1;
    assign pslverr = accessPhase && decErr_r;
    assign prdata = prdata_r;

    // Byte strobes expand to a bit mask for writes.
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : gStrb
            assign byteMask[gb*8 +: 8] = {8{pstrb[gb]}};
        end
    endgenerate

    // ------------------------------------------------------------
    // Read mux and address check
    // ------------------------------------------------------------
    // Unmapped offsets answer with an error and zero data. Reserved
    // positions of the source registers keep the default zero.
    always_comb begin
        prdata_nxt = 32'h00000000;
        decErr_nxt = 1'b0;
        if (paddr == lms_pkg::OFF_PAGE0_SRC) begin
            prdata_nxt[lms_pkg::UPPER_MSB:lms_pkg::UPPER_LSB] =
                srcReg_r[0].upper;
            prdata_nxt[lms_pkg::SIZE_MSB:lms_pkg::SIZE_LSB] =
                srcReg_r[0].sizeSel;
        end else if (paddr == lms_pkg::OFF_PAGE1_SRC) begin
            prdata_nxt[lms_pkg::UPPER_MSB:lms_pkg::UPPER_LSB] =
                srcReg_r[1].upper;
            prdata_nxt[lms_pkg::SIZE_MSB:lms_pkg::SIZE_LSB] =
                srcReg_r[1].sizeSel;
        end else if (paddr == lms_pkg::OFF_CTRL) begin
            prdata_nxt[lms_pkg::CTRL_XLAT_BIT] = xlatEn_r;
            prdata_nxt[lms_pkg::CTRL_PROT_BIT] = protEn_r;
        end else if (paddr == lms_pkg::OFF_LAST_SRC) begin
            prdata_nxt[lms_pkg::PADDR_W-1:0] = lastSrc_r;
        end else begin
            decErr_nxt = 1'b1;
        end
    end

    // Read data and decode error are captured during the setup cycle.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prdata_r <= 32'h00000000;
            decErr_r <= 1'b0;
        end else if (setupPhase) begin
            prdata_r <= pwrite ? 32'h00000000 : prdata_nxt;
            decErr_r <= decErr_nxt;
        end
    end

    // ------------------------------------------------------------
    // Source address registers
    // ------------------------------------------------------------
    // The generate loop gives each page its own always_ff; only the writable fields are
    // stored, so reserved bits cannot hold anything. The contents are
    // undefined by definition after reset; zero is one legal choice.
    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++) begin : gPage
            logic [7:0] pageOff;
            logic [31:0] wrVal;
            assign pageOff = (gp == 0) ? lms_pkg::OFF_PAGE0_SRC
                                       : lms_pkg::OFF_PAGE1_SRC;
            assign wrVal = pwdata & byteMask & lms_pkg::SRC_WMASK;
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    srcReg_r[gp].upper <= lms_pkg::UPPER_RST;
                    srcReg_r[gp].sizeSel <= lms_pkg::SIZE_RST;
                end else if (wrAccess && paddr == pageOff) begin
                    srcReg_r[gp].upper <=
                        (srcReg_r[gp].upper & ~byteMask[lms_pkg::UPPER_MSB:
                                                     lms_pkg::UPPER_LSB])
                        | wrVal[lms_pkg::UPPER_MSB:lms_pkg::UPPER_LSB];
                    srcReg_r[gp].sizeSel <=
                        (srcReg_r[gp].sizeSel & ~byteMask[lms_pkg::SIZE_MSB:
                                                       lms_pkg::SIZE_LSB])
                        | wrVal[lms_pkg::SIZE_MSB:lms_pkg::SIZE_LSB];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Mode control register
    // ------------------------------------------------------------
    // Both mode bits sit in byte lane 0.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            xlatEn_r <= lms_pkg::CTRL_XLAT_RST;
            protEn_r <= lms_pkg::CTRL_PROT_RST;
        end else if (wrAccess && paddr == lms_pkg::OFF_CTRL && pstrb[0]) begin
            xlatEn_r <= pwdata[lms_pkg::CTRL_XLAT_BIT];
            protEn_r <= pwdata[lms_pkg::CTRL_PROT_BIT];
        end
    end

    assign addressTranslationEnable = xlatEn_r;
    assign onchipMemoryProtectionEnable = protEn_r;
    // Checks apply only to translated accesses with protection on.
    assign protCheckActive = xlatEn_r && protEn_r;

    // ------------------------------------------------------------
    // Transfer source address formation
    // ------------------------------------------------------------
    // The register path is used whenever translation or protection is
    // off; otherwise the operand passes and the translation logic owns
    // the address. Illegal size patterns are not screened: the merge
    // stays per bit, which costs nothing and leaves software in charge.
    assign useRegs = !xlatEn_r || !protEn_r;
    assign selReg = xferIn.page ? srcReg_r[1] : srcReg_r[0];

    lms_addr_mux uMux (
        .useRegs(useRegs),
        .srcReg(selReg),
        .operand(xferIn.operand),
        .srcAddr(mergedAddr)
    );

    // The result is registered, valid one cycle after the request and held until the next request.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            xferDone_r <= 1'b0;
        end else begin
            xferDone_r <= xferReq;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            xferOut_r <= '0;
        end else if (xferReq) begin
            xferOut_r.fromRegs <= useRegs;
            xferOut_r.srcAddr <= mergedAddr;
        end
    end

    // Software can read back the last address formed.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            lastSrc_r <= '0;
        end else if (xferReq) begin
            lastSrc_r <= mergedAddr;
        end
    end

    assign xferDone = xferDone_r;
    assign xferOut = xferOut_r;

endmodule

// ---- sim/lms_src_addr_chk.sv ----
// Port checker of the source-address unit and its bind.
`timescale 1ns/10ps
// ------------------------------------------------------------
// Checker
// ------------------------------------------------------------
module lms_src_addr_chk (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic xferReq,
    input wire lms_pkg::lms_xfer_req_s xferIn,
    input wire logic xferDone,
    input wire lms_pkg::lms_xfer_rsp_s xferOut,
    input wire logic addressTranslationEnable,
    input wire logic onchipMemoryProtectionEnable,
    input wire logic protCheckActive
);
    // One clock domain; nothing is judged while reset is high.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic bothOn;
    assign bothOn = addressTranslationEnable && onchipMemoryProtectionEnable;
    // Transfer timing, path choice and hold of the answer.
    chk_done_timing: assert property (xferDone == $past(xferReq))
        else $error("done pulse not one cycle after request");
    chk_bypass_oper: assert property (xferReq && bothOn |=>
        xferOut == {1'b0, $past(xferIn[28:0])})
        else $error("operand not passed with both modes on");
    chk_low_operand: assert property (xferReq |=>
        xferOut.srcAddr[9:0] == $past(xferIn[9:0]))
        else $error("low address bits not from operand");
    chk_regs_path: assert property (xferReq && !bothOn |=>
        xferOut.fromRegs) else $error("register path not flagged");
    chk_out_stable: assert property (!xferReq |=> $stable(xferOut))
        else $error("transfer answer changed without request");
    // Mode outputs and register access.
    chk_prot_and: assert property (protCheckActive == bothOn)
        else $error("protection check level wrong");
    chk_ctrl_write: assert property (psel && penable && pwrite &&
        pready && paddr == lms_pkg::OFF_CTRL && pstrb[0] |=>
        addressTranslationEnable == $past(pwdata[0]) &&
        onchipMemoryProtectionEnable == $past(pwdata[1]))
        else $error("mode bits not written");
    chk_rsv_zero: assert property (psel && penable && !pwrite &&
        (paddr == lms_pkg::OFF_PAGE0_SRC || paddr == lms_pkg::OFF_PAGE1_SRC)
        |-> (prdata & ~lms_pkg::SRC_WMASK) == 32'h0)
        else $error("reserved bits read nonzero");
    chk_unmapped_err: assert property (psel && penable &&
        paddr > lms_pkg::OFF_LAST_SRC |-> pslverr)
        else $error("unmapped access without error");
    cover property (xferReq && bothOn);
    cover property (xferReq && !addressTranslationEnable);
    cover property (psel && penable && pslverr);
endmodule
bind lms_src_addr lms_src_addr_chk u_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .xferReq(xferReq),
    .xferIn(xferIn), .xferDone(xferDone), .xferOut(xferOut),
    .addressTranslationEnable(addressTranslationEnable),
    .onchipMemoryProtectionEnable(onchipMemoryProtectionEnable),
    .protCheckActive(protCheckActive)
);

// ---- sim/lms_src_addr_tb.sv ----
// Self-checking testbench of the source-address unit.
`timescale 1ns/10ps
// ------------------------------------------------------------
// Testbench
// ------------------------------------------------------------
module lms_src_addr_tb;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, sh [2];
    logic [3:0] pstrb = 4'hF;
    logic xferReq = 1'b0, xferDone, at, rp, pca, shAt, shRp;
    lms_pkg::lms_xfer_req_s xferIn = 30'h0;
    lms_pkg::lms_xfer_rsp_s xferOut;
    logic [32:0] readQ [$];
    logic [29:0] xferQ [$];
    logic [28:0] lastA;
    logic [5:0] codes [7] = '{6'h3F, 6'h3E, 6'h3C, 6'h38, 6'h30, 6'h20, 6'h00};
    int miscompares = 0, comparisons = 0, cyc = 0;
    lms_src_addr dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .xferReq(xferReq), .xferIn(xferIn), .xferDone(xferDone),
        .xferOut(xferOut), .addressTranslationEnable(at),
        .onchipMemoryProtectionEnable(rp), .protCheckActive(pca));
    // Free-running 10 MHz clock.
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    task check(input string name, input logic [32:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Reference merge, kept independent of the design's own mux.
    function logic [29:0] model(input logic [31:0] r, input logic [28:0] op);
        logic [28:0] s;
        s = op;
        if (!(shAt && shRp)) begin
            s[28:16] = r[28:16];
            for (int i = 0; i < 6; i++) if (r[i]) s[10+i] = r[10+i];
        end
        return {!(shAt && shRp), s};
    endfunction
    // One APB transfer; the request is held until pready is seen high.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        if (a == 8'h00 || a == 8'h04) sh[a[2]] = d & lms_pkg::SRC_WMASK;
        if (a == lms_pkg::OFF_CTRL) {shRp, shAt} = d[1:0];
    endtask
    task rd(input logic [7:0] a, input logic [32:0] exp);
        readQ.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask
    // Back-to-back transfers with random page and operand.
    task xfers(input int n);
        logic [28:0] op;
        logic [29:0] e;
        logic pg;
        repeat (n) begin
            @(posedge sys_clk);
            op = 29'($urandom);
            pg = 1'($urandom);
            xferReq <= 1'b1; xferIn <= {pg, op};
            e = model(sh[pg], op);
            xferQ.push_back(e);
            lastA = e[28:0];
        end
        @(posedge sys_clk);
        xferReq <= 1'b0;
    endtask
    // Watcher: each answer is matched with the oldest note.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            complete_run;
        end else begin
            if (!sys_rst && xferDone === 1'b1)
                check("xferOut", {3'h0, xferOut}, {3'h0, xferQ.pop_front()});
            if (psel && penable && pready === 1'b1 && !pwrite)
                check("prdata", {pslverr, prdata}, readQ.pop_front());
        end
    end
    // Main sequence: two resets with reset values, register access, every size code in
    // every mode and refused accesses.
    initial begin
        void'($urandom(7650));
        for (int k = 0; k < 2; k++) begin
            sh = '{32'h0, 32'h0}; shAt = 1'b0; shRp = 1'b0;
            sys_rst <= 1'b1;
            repeat (10) @(posedge sys_clk);
            sys_rst <= 1'b0;
            for (int a = 0; a < 12; a += 4) rd(8'(a), 33'h0);
        end
        wr(8'h00, 32'hFFFFFFFF);
        // Only permitted size codes are ever written by this bench.
        wr(8'h04, ($urandom & 32'hFFFFFFC0) | codes[1]);
        rd(8'h00, {1'b0, sh[0]});
        rd(8'h04, {1'b0, sh[1]});
        for (int m = 0; m < 4; m++) for (int c = 0; c < 7; c++) begin
            wr(8'h00, ($urandom & 32'hFFFFFFC0) | codes[c]);
            wr(8'h04, ($urandom & 32'hFFFFFFC0) | codes[(c + 3) % 7]);
            wr(lms_pkg::OFF_CTRL, 32'(m));
            @(posedge sys_clk);
            check("modes", 33'({pca, rp, at}), 33'({m == 3, m[1], m[0]}));
            xfers(4);
        end
        wr(lms_pkg::OFF_LAST_SRC, 32'hFFFFFFFF);
        rd(lms_pkg::OFF_LAST_SRC, {4'h0, lastA});
        wr(8'h10, 32'hFFFFFFFF);
        rd(8'h10, {1'b1, 32'h0});
        rd(8'h04, {1'b0, sh[1]});
        repeat (3) @(posedge sys_clk);
        check("pending", 33'(xferQ.size() + readQ.size()), 33'h0);
        complete_run;
    end
endmodule
